// >>> design/tws_eeprom_port.sv
// Top of the three-wire serial EEPROM port: word array, instruction
// decode, self-timed programming and the serial output pin.
// Assumes the host drives select, clock and data; serial_out is
// three-stated outside by serial_out_en.

module tws_eeprom_port
    import tws_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic shift_clock,
    input wire logic select_in,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if ((PROG_CYCLES < 1) || (PROG_CYCLES >= (1 << TIMER_W)))
    begin : g_chk_prog
        $error("PROG_CYCLES must be at least 1 and fit the timer");
    end

    if ((1 + HDR_W + DATA_W) >= (1 << CNT_W))
    begin : g_chk_cnt
        $error("Link bit counter too narrow for a full frame");
    end

    if (DATA_W >= (1 << RD_CNT_W))
    begin : g_chk_rd
        $error("Read bit counter too narrow for one word");
    end

    if ((OP_MSB != HDR_W - 1) || (SUB_MSB != ADDR_W - 1))
    begin : g_chk_fields
        $error("Header field positions do not match the widths");
    end

    localparam logic [TIMER_W-1:0] PROG_LOAD = TIMER_W'(PROG_CYCLES);
    localparam logic [TIMER_W-1:0] TIMER_ONE = 21'h000001;
    localparam logic [RD_CNT_W-1:0] RD_ONE = 5'h01;
    localparam logic [RD_CNT_W-1:0] RD_FULL = RD_CNT_W'(DATA_W);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Link domain and crossings
    // ------------------------------------------------------------
    logic [HDR_W-1:0] hdr_word;
    logic [DATA_W-1:0] dat_word;
    logic hdr_tgl;
    logic dat_tgl;
    logic shf_tgl;
    logic sel_lvl;
    logic hdr_pulse;
    logic dat_pulse;
    logic shf_pulse;

    tws_link u_link (
        .shift_clock(shift_clock),
        .rst_b(rst_sync_q),
        .select_in(select_in),
        .serial_in(serial_in),
        .hdr_word(hdr_word),
        .dat_word(dat_word),
        .hdr_tgl(hdr_tgl),
        .dat_tgl(dat_tgl),
        .shf_tgl(shf_tgl)
    );

    tws_sync u_sync_sel (
        .clk(clk_sys),
        .rst_b(rst_sync_q),
        .din(select_in),
        .lvl(sel_lvl),
        .pulse()
    );

    // Words are read only on a header or data toggle; they have been stable since
    // the link edge, several system cycles earlier
    tws_sync u_sync_hdr (
        .clk(clk_sys),
        .rst_b(rst_sync_q),
        .din(hdr_tgl),
        .lvl(),
        .pulse(hdr_pulse)
    );

    tws_sync u_sync_dat (
        .clk(clk_sys),
        .rst_b(rst_sync_q),
        .din(dat_tgl),
        .lvl(),
        .pulse(dat_pulse)
    );

    tws_sync u_sync_shf (
        .clk(clk_sys),
        .rst_b(rst_sync_q),
        .din(shf_tgl),
        .lvl(),
        .pulse(shf_pulse)
    );

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    tws_port_s q;
    tws_port_s d;

    always_comb
    begin
        logic [1:0] op;
        logic [1:0] sub;
        logic [ADDR_W-1:0] adr;
        logic start;
        logic [ADDR_W-1:0] st_addr;
        logic [DATA_W-1:0] st_word;
        logic st_all;
        logic sel_rise;
        op = hdr_word[OP_MSB:OP_LSB];
        sub = hdr_word[SUB_MSB:SUB_LSB];
        adr = hdr_word[ADDR_W-1:0];
        start = 1'b0;
        st_addr = adr;
        st_word = ERASED_WORD;
        st_all = 1'b0;
        sel_rise = sel_lvl & ~q.sel_prev;
        d = q;
        d.sel_prev = sel_lvl;

        // A header that lands while busy is refused, so its data must not
        // start a write even when it arrives after the cycle has ended
        if (hdr_pulse)
        begin
            d.hdr_ok = (q.state == ST_IDLE);
        end

        case (q.state)
            ST_IDLE:
            begin
                if (hdr_pulse)
                begin
                    case (op)
                        OP_READ:
                        begin
                            // No enable check here: reads never depend on it
                            d.rd_word = q.mem[adr];
                            d.so = DUMMY_BIT;
                            d.rd_left = RD_FULL;
                            d.state = ST_READ;
                        end
                        OP_ERASE:
                        begin
                            start = q.prog_en;
                        end
                        OP_SPECIAL:
                        begin
                            case (sub)
                                SUB_ENABLE:
                                begin
                                    d.prog_en = 1'b1;
                                end
                                SUB_DISABLE:
                                begin
                                    d.prog_en = 1'b0;
                                end
                                SUB_ERASE_ALL:
                                begin
                                    start = q.prog_en;
                                    st_all = 1'b1;
                                end
                                default:
                                begin
                                    start = 1'b0;
                                end
                            endcase
                        end
                        default:
                        begin
                            start = 1'b0;
                        end
                    endcase
                end
                else if (dat_pulse && q.hdr_ok)
                begin
                    // Data words always replace the old value; no erase pass
                    st_word = dat_word;
                    if (op == OP_WRITE)
                    begin
                        start = q.prog_en;
                    end
                    else if ((op == OP_SPECIAL) && (sub == SUB_WRITE_ALL))
                    begin
                        start = q.prog_en;
                        st_all = 1'b1;
                    end
                end
            end
            ST_READ:
            begin
                if (!sel_lvl)
                begin
                    d.state = ST_IDLE;
                end
                else if (shf_pulse)
                begin
                    if (q.rd_left != '0)
                    begin
                        d.so = q.rd_word[DATA_W-1];
                        d.rd_word = {q.rd_word[DATA_W-2:0], 1'b0};
                        d.rd_left = q.rd_left - RD_ONE;
                    end
                    else
                    begin
                        d.so = 1'b0;
                    end
                end
            end
            ST_BUSY:
            begin
                // Array is committed at the end of the timed cycle
                if (q.timer <= TIMER_ONE)
                begin
                    d.timer = '0;
                    d.state = ST_IDLE;
                    if (q.prog_all)
                    begin
                        for (int i = 0; i < WORDS; i++)
                        begin
                            d.mem[i] = q.prog_word;
                        end
                    end
                    else
                    begin
                        d.mem[q.prog_addr] = q.prog_word;
                    end
                end
                else
                begin
                    d.timer = q.timer - TIMER_ONE;
                end
            end
            default:
            begin
                d.state = ST_IDLE;
            end
        endcase

        if (start)
        begin
            d.state = ST_BUSY;
            d.timer = PROG_LOAD;
            d.prog_addr = st_addr;
            d.prog_word = st_word;
            d.prog_all = st_all;
            d.stat_arm = 1'b1;
        end

        // Status only for a reselect that lands inside the timed cycle
        if (sel_rise && q.stat_arm && (q.state == ST_BUSY))
        begin
            d.stat_show = 1'b1;
        end
        if (!sel_lvl)
        begin
            d.stat_show = 1'b0;
            if (d.state != ST_BUSY)
            begin
                d.stat_arm = 1'b0;
            end
        end
        if (d.stat_show)
        begin
            d.so = (d.state == ST_BUSY) ? STATUS_BUSY : STATUS_READY;
        end

        d.so_en = sel_lvl && ((d.state == ST_READ) || d.stat_show);
    end

    always_ff @(posedge clk_sys or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            q <= PORT_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    assign serial_out = q.so;
    assign serial_out_en = q.so_en;

endmodule

// >>> design/tws_pkg.sv
// Shared constants and types for the three-wire serial EEPROM port.
// Assumes a system clock of 125 MHz; the link clock comes from the host.
package tws_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int WORDS = 64;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int OP_W = 2;
    localparam int HDR_W = OP_W + ADDR_W;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

    // ------------------------------------------------------------
    // Instruction fields inside the header word (opcode then address)
    // ------------------------------------------------------------
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 6;
    localparam int SUB_MSB = 5;
    localparam int SUB_LSB = 4;
    localparam logic [1:0] OP_SPECIAL = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SUB_ENABLE = 2'h3;

    // ------------------------------------------------------------
    // Link bit counting: start bit, header, data
    // ------------------------------------------------------------
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_START = 5'h01;
    localparam logic [CNT_W-1:0] CNT_HDR_DONE = CNT_W'(1 + HDR_W);
    localparam logic [CNT_W-1:0] CNT_DATA_DONE = CNT_W'(1 + HDR_W + DATA_W);
    localparam int RD_CNT_W = 5;
    localparam logic DUMMY_BIT = 1'b0;
    localparam logic STATUS_READY = 1'b1;
    localparam logic STATUS_BUSY = 1'b0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_SYS_KHZ = 125000;
    localparam int TWP_MAX_MS = 10;
    // Longest time, so rounded down; exact at this rate
    localparam int PROG_CYCLES_DFLT = TWP_MAX_MS * CLK_SYS_KHZ;
    localparam int TIMER_W = 21;

    // ------------------------------------------------------------
    // Controller state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_READ = 3'h2,
        ST_BUSY = 3'h4
    } tws_state_e;

    typedef struct packed {
        tws_state_e state;
        logic prog_en;
        logic [ADDR_W-1:0] prog_addr;
        logic [DATA_W-1:0] prog_word;
        logic prog_all;
        logic hdr_ok;
        logic [TIMER_W-1:0] timer;
        logic [DATA_W-1:0] rd_word;
        logic [RD_CNT_W-1:0] rd_left;
        logic stat_arm;
        logic stat_show;
        logic sel_prev;
        logic so;
        logic so_en;
        logic [WORDS-1:0][DATA_W-1:0] mem;
    } tws_port_s;

    localparam tws_port_s PORT_RST = '{state: ST_IDLE, default: '0};

endpackage

// >>> design/tws_sync.sv
// Two-flop synchroniser with a change detector on the synchronised copy.
// Assumes din is a level or a toggle from another clock domain.
module tws_sync
    import tws_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic din,
    output logic lvl,
    output logic pulse
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } tws_sync_s;

    tws_sync_s q;

    // Only the second stage reads the first
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= '{meta: din, sync: q.meta, prev: q.sync};
        end
    end

    assign lvl = q.sync;
    assign pulse = q.sync ^ q.prev;

endmodule

// >>> design/tws_link.sv
// Link-side shifter on the host's shift clock.
// Assumes select_in and serial_in meet set-up to rising shift_clock edges.
module tws_link
    import tws_pkg::*;
(
    input wire logic shift_clock,
    input wire logic rst_b,
    input wire logic select_in,
    input wire logic serial_in,
    output logic [HDR_W-1:0] hdr_word,
    output logic [DATA_W-1:0] dat_word,
    output logic hdr_tgl,
    output logic dat_tgl,
    output logic shf_tgl
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [HDR_W-1:0] hdr;
        logic [DATA_W-1:0] dat;
        logic hdr_tgl;
        logic dat_tgl;
        logic shf_tgl;
    } tws_link_s;

    tws_link_s q;
    tws_link_s d;
    logic armed_q;
    logic arm_rst_b;

    // The clock may stop with select low, so a dropped select clears the
    // frame asynchronously; toggles stay out of it to avoid false events
    assign arm_rst_b = rst_b & select_in;

    always_ff @(posedge shift_clock or negedge arm_rst_b)
    begin
        if (!arm_rst_b)
        begin
            armed_q <= 1'b0;
        end
        else
        begin
            armed_q <= 1'b1;
        end
    end

    always_comb
    begin
        logic [CNT_W-1:0] cnt_now;
        logic [1:0] op;
        logic needs_data;
        cnt_now = armed_q ? q.cnt : '0;
        op = q.hdr[OP_MSB:OP_LSB];
        needs_data = (op == OP_WRITE) ||
            ((op == OP_SPECIAL) && (q.hdr[SUB_MSB:SUB_LSB] == SUB_WRITE_ALL));
        d = q;
        d.cnt = cnt_now;
        if (select_in)
        begin
            if (cnt_now == '0)
            begin
                if (serial_in)
                begin
                    d.cnt = CNT_START;
                end
            end
            else if (cnt_now < CNT_HDR_DONE)
            begin
                d.hdr = {q.hdr[HDR_W-2:0], serial_in};
                d.cnt = cnt_now + CNT_START;
                if (cnt_now == CNT_HDR_DONE - CNT_START)
                begin
                    d.hdr_tgl = ~q.hdr_tgl;
                end
            end
            else if (needs_data && (cnt_now < CNT_DATA_DONE))
            begin
                d.dat = {q.dat[DATA_W-2:0], serial_in};
                d.cnt = cnt_now + CNT_START;
                if (cnt_now == CNT_DATA_DONE - CNT_START)
                begin
                    d.dat_tgl = ~q.dat_tgl;
                end
            end
            else if (op == OP_READ)
            begin
                d.shf_tgl = ~q.shf_tgl;
            end
        end
    end

    always_ff @(posedge shift_clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Header and data stand still from their toggle until the next frame
    assign hdr_word = q.hdr;
    assign dat_word = q.dat;
    assign hdr_tgl = q.hdr_tgl;
    assign dat_tgl = q.dat_tgl;
    assign shf_tgl = q.shf_tgl;

endmodule

// >>> tb/tws_port_props.sv
// Pin checker for the serial port, sampled on the system clock.
// Assumes the host stops shift_clock between frames and while polling status.
module tws_port_props
    import tws_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic shift_clock,
    input wire logic select_in,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic sk_q;
    logic [4:0] lk_q;
    logic [3:0] since_q;
    logic [TIMER_W:0] busy_q;
    logic sk_rise;

    assign sk_rise = shift_clock && !sk_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sk_q <= 1'b0;
            lk_q <= '0;
            since_q <= 4'hF;
            busy_q <= '0;
        end
        else
        begin
            sk_q <= shift_clock;
            if (!select_in)
                lk_q <= '0;
            else if (sk_rise && lk_q != 5'h1F)
                lk_q <= lk_q + 5'h01;
            if (sk_rise)
                since_q <= '0;
            else if (since_q != 4'hF)
                since_q <= since_q + 4'h1;
            if (serial_out_en && lk_q == 5'h00 && !serial_out)
                busy_q <= busy_q + 1'b1;
            else
                busy_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_release_deselected: assert property (!select_in [*6] |-> !serial_out_en)
        else $error("serial_out driven while deselected");
    a_drop_after_desel: assert property ($fell(select_in) |-> ##[1:6] !serial_out_en)
        else $error("serial_out not released after select fell");
    a_read_start_time: assert property ($rose(serial_out_en) && lk_q != 5'h00
        |-> lk_q == 5'h09 && since_q inside {[1:6]})
        else $error("read output not started after ninth bit");
    a_dummy_bit_zero: assert property ($rose(serial_out_en) && lk_q == 5'h09 |-> !serial_out)
        else $error("dummy bit not zero");
    a_out_steps_link: assert property (serial_out_en && $past(serial_out_en)
        && $changed(serial_out) && lk_q != 5'h00 |-> since_q inside {[1:6]})
        else $error("read output changed away from a link edge");
    a_status_busy_first: assert property ($rose(serial_out_en) && lk_q == 5'h00
        |-> !serial_out && !$past(select_in, 8))
        else $error("status not busy on reselect");
    a_ready_bound: assert property (busy_q <= PROG_CYCLES)
        else $error("busy status lasted too long");
    a_ready_stays: assert property (serial_out_en && lk_q == 5'h00 && serial_out
        |=> serial_out || !serial_out_en)
        else $error("ready status fell back");
endmodule

// >>> tb/tws_host.sv
// Host model driving select, shift clock and serial data.
// Assumes the caller deselects after each frame with desel.
module tws_host
(
    output logic shift_clock,
    output logic select_in,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        shift_clock = 1'b0;
        select_in = 1'b0;
        serial_in = 1'b0;
    end

    // Sends bits[n-1:0] MSB first; samples the pin before edges 10 to n
    task automatic xfer(input logic [25:0] bits, input int n, output logic [16:0] rd);
        rd = '0;
        select_in = 1'b1;
        #64;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in = bits[i];
            #32;
            if (n - i >= 10)
                rd = {rd[15:0], serial_out_en ? serial_out : 1'bx};
            // Faster than a real host may clock it; the port needs only
            // eight system cycles a bit
            shift_clock = 1'b1;
            #32;
            shift_clock = 1'b0;
        end
        // No keeper on the data line
        serial_in = ~serial_in;
    endtask

    task automatic desel();
        #32;
        select_in = 1'b0;
        #256;
    endtask

    task automatic sel();
        select_in = 1'b1;
    endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the serial EEPROM port with a shortened program time.
// Assumes the host model for the link side.
module testbench
    import tws_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned PROG = 200;
    logic clk_sys;
    logic rst_b;
    logic shift_clock;
    logic select_in;
    logic serial_in;
    logic serial_out;
    logic serial_out_en;
    int n_errors = 0;
    int cmp_count = 0;

    tws_eeprom_port #(.PROG_CYCLES(PROG)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .shift_clock(shift_clock), .select_in(select_in), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_en(serial_out_en));
    tws_host i_host (.shift_clock(shift_clock), .select_in(select_in),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task automatic check_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic read_chk(input logic [5:0] a, input logic [15:0] exp);
        logic [16:0] rd;
        i_host.xfer({3'b110, a, 17'h0}, 26, rd);
        check_bit(rd[16], DUMMY_BIT, "dummy");
        check_word(rd[15:0], exp, "read");
        i_host.desel();
    endtask

    task automatic cmd(input logic [25:0] bits, input int n);
        logic [16:0] rd;
        i_host.xfer(bits, n, rd);
        i_host.desel();
    endtask

    // Frame, deselect, reselect, then follow the ready/busy status
    task automatic prog(input logic [25:0] bits, input int n, input logic armed);
        int k;
        cmd(bits, n);
        i_host.sel();
        repeat (10) @(posedge clk_sys);
        #1;
        check_bit(serial_out_en, armed, "status drive");
        if (armed)
        begin
            check_bit(serial_out, STATUS_BUSY, "busy");
            k = 0;
            while (serial_out !== STATUS_READY && k < PROG + 20)
            begin
                @(posedge clk_sys);
                #1;
                k++;
            end
            check_bit(serial_out, STATUS_READY, "ready");
        end
        i_host.desel();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_up();
        check_bit(serial_out_en, 1'b0, "idle drive");
        prog({1'b0, 3'b101, 6'h03, 16'h1234}, 25, 1'b0);
        read_chk(6'h03, 16'h0000);
        $display("test power_up done");
    endtask

    task automatic t_write();
        cmd({17'h0, 9'b100110000}, 9);
        prog({1'b0, 3'b101, 6'h2A, 16'hA5C3}, 25, 1'b1);
        read_chk(6'h2A, 16'hA5C3);
        prog({1'b0, 3'b101, 6'h2A, 16'h0F0F}, 25, 1'b1);
        read_chk(6'h2A, 16'h0F0F);
        $display("test write done");
    endtask

    task automatic t_erase();
        prog({17'h0, 3'b111, 6'h2A}, 9, 1'b1);
        read_chk(6'h2A, ERASED_WORD);
        read_chk(6'h2B, 16'h0000);
        $display("test erase done");
    endtask

    task automatic t_all();
        prog({1'b0, 3'b100, 6'h10, 16'h5A0F}, 25, 1'b1);
        read_chk(6'h00, 16'h5A0F);
        read_chk(6'h3F, 16'h5A0F);
        prog({17'h0, 3'b100, 6'h20}, 9, 1'b1);
        read_chk(6'h11, ERASED_WORD);
        $display("test all_words done");
    endtask

    task automatic t_abort_disable();
        cmd({3'b101, 6'h05, 16'h0000} >> 10, 15);
        read_chk(6'h05, ERASED_WORD);
        cmd({17'h0, 9'b100000000}, 9);
        prog({1'b0, 3'b101, 6'h05, 16'h0000}, 25, 1'b0);
        prog({17'h0, 3'b100, 6'h20}, 9, 1'b0);
        read_chk(6'h05, ERASED_WORD);
        $display("test abort_disable done");
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        rst_b = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        repeat (10) @(posedge clk_sys);
        #1;
        t_power_up();
        t_write();
        t_erase();
        t_all();
        t_abort_disable();
        stop_test();
    end

    // About 21 frames of a few microseconds each
    initial
    begin
        #500us;
        n_errors++;
        $display("[ERR] %0t run did not finish", $time);
        stop_test();
    end
endmodule

bind tws_eeprom_port tws_port_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (.clk_sys(clk_sys),
    .rst_b(rst_b), .shift_clock(shift_clock), .select_in(select_in), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en));
